/* dv/dpbc_ram_model.sv */
// far-side dual-port ram model: host port pins plus a camped other port
// assumes the other port is steered by the bench and always wins
`timescale 1ns/10ps

module dpbc_ram_model (
    // host port pins
    input wire dpbc_pkg::dpbc_pins_t pins,
    output logic [7:0] din,
    output logic busy_n,
    // other port
    input wire logic other_en,
    input wire logic [12:0] other_addr
);
    logic [7:0] mem [0:8191];
    logic [12:0] idx;
    logic sel;
    logic match;

    initial begin
        busy_n = 1'b1;
        din = 8'h00;
    end

    // one-hot active-low selects back to block bits
    always_comb begin
        sel = 1'b0;
        idx = {2'h0, pins.addr};
        for (int i = 0; i < 4; i++) begin
            if (!pins.sel_n[i]) begin
                sel = 1'b1;
                idx[12:11] = i[1:0];
            end
        end
    end

    // camped winner, host loses
    assign match = other_en && sel && (other_addr == idx);

    // busy follows the match after a delay
    always @(match) busy_n <= #30 !match;

    // invert at once, data one access later
    always @(pins or busy_n) begin
        din = ~din; // released bus never shows the last value
        if (sel && pins.rw_n) din <= #35 mem[idx];
    end

    // write lands at pulse end; inhibit fast, busy slow
    always @(pins or match) begin
        #11;
        if (sel && !pins.rw_n && !match) mem[idx] = pins.dout;
    end
endmodule : dpbc_ram_model

/* dv/testbench.sv */
// self-checking bench for the host-side dual-port busy controller
// assumes dpbc_ram_model on the pins; short retry count of 2
`timescale 1ns/10ps
`include "dpbc_regs.svh"

module testbench;
    logic clk, reset, ce, req_valid, req_write, other_en;
    logic [12:0] req_addr, other_addr;
    logic [7:0] req_wdata, rd;
    logic req_ready, resp_valid, resp_retried, snap_irq, ram_busy_n;
    logic [7:0] resp_rdata, ram_din;
    dpbc_pkg::dpbc_snap_t snap;
    dpbc_pkg::dpbc_pins_t ram_o;
    int n_mismatch, num_checks, lat, n_irq;
    // outputs of the second pair, which retries by flipping an address line
    logic [7:0] resp_rdata_a, ram_din_a;
    logic resp_valid_a, resp_retried_a, ram_busy_n_a;
    dpbc_pkg::dpbc_pins_t ram_o_a;

    dpbc_host #(.RETRY_CYC(2)) u_dpbc_host (.clk(clk), .reset(reset),
        .ce(ce), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .resp_retried(resp_retried), .snap_irq(snap_irq), .snap(snap),
        .ram_o(ram_o), .ram_din(ram_din), .ram_busy_n(ram_busy_n));
    dpbc_ram_model u_dpbc_ram_model (.pins(ram_o), .din(ram_din),
        .busy_n(ram_busy_n), .other_en(other_en), .other_addr(other_addr));

    // same requests and same camped port; only the retry style differs
    if (1) begin : g_addr_mode
        dpbc_host #(.RETRY_CYC(2), .RETRY_MODE(`DPBC_RETRY_ADDR))
            u_dpbc_host (.clk(clk), .reset(reset), .ce(ce),
            .req_valid(req_valid), .req_ready(), .req_write(req_write),
            .req_addr(req_addr), .req_wdata(req_wdata),
            .resp_valid(resp_valid_a), .resp_rdata(resp_rdata_a),
            .resp_retried(resp_retried_a), .snap_irq(), .snap(),
            .ram_o(ram_o_a), .ram_din(ram_din_a),
            .ram_busy_n(ram_busy_n_a));
        dpbc_ram_model u_dpbc_ram_model (.pins(ram_o_a), .din(ram_din_a),
            .busy_n(ram_busy_n_a), .other_en(other_en),
            .other_addr(other_addr));
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // interrupt pulses counted at settled points
    always @(negedge clk) if (snap_irq === 1'b1) n_irq++;

    task automatic chk_val(input string what, input logic [13:0] exp,
                           input logic [13:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_bit(input string what, input logic exp,
                           input logic got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    // one request, held until taken; lat counts cycles to the answer
    task automatic do_req(input logic wr, input logic [12:0] a,
                          input logic [7:0] d);
        int guard;
        guard = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        while (req_ready !== 1'b1 && guard < 100) begin
            @(negedge clk);
            guard++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        lat = 1;
        while (resp_valid !== 1'b1 && lat < 400) begin
            @(negedge clk);
            lat++;
        end
        chk_bit("resp_valid", 1'b1, resp_valid);
        chk_bit("resp_valid_a", 1'b1, resp_valid_a);
        rd = resp_rdata;
    endtask : do_req

    task automatic t_reset;
        chk_val("sel_n", 14'h000F, {10'h0, ram_o.sel_n});
        chk_bit("dout_oe_n", 1'b1, ram_o.dout_oe_n);
        chk_bit("req_ready", 1'b1, req_ready);
        $display("test reset done");
    endtask : t_reset

    // each block select decoded from the top bits, no contention
    task automatic t_plain;
        for (int b = 0; b < 4; b++) begin
            do_req(1'b1, {b[1:0], 11'h405}, 8'hA0 + 8'(b));
            chk_val("wr_lat", 14'h6, 14'(lat));
        end
        for (int b = 0; b < 4; b++) begin
            do_req(1'b0, {b[1:0], 11'h405}, 8'h00);
            chk_val("rd_lat", 14'h6, 14'(lat));
            chk_val("rdata", 14'(8'hA0 + 8'(b)), 14'(rd));
            chk_bit("retried", 1'b0, resp_retried);
        end
        $display("test plain done");
    endtask : t_plain

    // clock enable low for four edges stretches a read by four cycles
    task automatic t_ce;
        fork
            do_req(1'b0, 13'h0405, 8'h00);
            begin
                repeat (3) @(negedge clk);
                ce = 1'b0;
                repeat (4) @(negedge clk);
                chk_bit("ready_frozen", 1'b0, req_ready);
                ce = 1'b1;
            end
        join
        chk_val("ce_lat", 14'hA, 14'(lat));
        chk_val("ce_rdata", 14'hA0, 14'(rd));
        $display("test ce done");
    endtask : t_ce

    // write against a camped winner, released later
    task automatic t_wr_busy;
        u_dpbc_ram_model.mem[13'h1234] = 8'h11;
        g_addr_mode.u_dpbc_ram_model.mem[13'h1235] = 8'h5A;
        other_addr = 13'h1234;
        other_en = 1'b1;
        n_irq = 0;
        fork
            do_req(1'b1, 13'h1234, 8'hC3);
            begin
                repeat (20) @(negedge clk);
                chk_val("snap", {13'h1234, 1'b1}, snap);
                chk_bit("irq_seen", 1'b1, n_irq != 0);
                chk_bit("stalled", 1'b0, resp_valid);
                other_en = 1'b0;
            end
        join
        chk_bit("retried", 1'b1, resp_retried);
        do_req(1'b0, 13'h1234, 8'h00);
        chk_val("reissued", 14'hC3, 14'(rd));
        chk_val("reissued_a", 14'hC3, 14'(resp_rdata_a));
        chk_val("neighbour", 14'h5A,
                14'(g_addr_mode.u_dpbc_ram_model.mem[13'h1235]));
        chk_bit("retried_clr", 1'b0, resp_retried);
        $display("test write busy done");
    endtask : t_wr_busy

    // read while the winner rewrites; two toggles, winner leaves just before a check
    task automatic t_rd_busy;
        u_dpbc_ram_model.mem[13'h0A0F] = 8'h22;
        g_addr_mode.u_dpbc_ram_model.mem[13'h0A0F] = 8'h22;
        other_addr = 13'h0A0F;
        other_en = 1'b1;
        fork
            do_req(1'b0, 13'h0A0F, 8'h00);
            begin
                repeat (15) @(negedge clk);
                u_dpbc_ram_model.mem[13'h0A0F] = 8'h96;
                g_addr_mode.u_dpbc_ram_model.mem[13'h0A0F] = 8'h96;
                // busy rises while both hosts sit in the check state
                repeat (10) @(negedge clk);
                other_en = 1'b0;
            end
        join
        chk_val("fresh_rd", 14'h96, 14'(rd));
        chk_bit("retried", 1'b1, resp_retried);
        chk_val("fresh_rd_a", 14'h96, 14'(resp_rdata_a));
        chk_bit("retried_a", 1'b1, resp_retried_a);
        $display("test read busy done");
    endtask : t_rd_busy

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // watchdog well beyond the fewer than two hundred cycles the tests need
    initial begin
        #(50 * 5000);
        n_mismatch++;
        close_out();
    end

    initial begin
        reset = 1'b1;
        ce = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 13'h0000;
        req_wdata = 8'h00;
        other_en = 1'b0;
        other_addr = 13'h0000;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        t_reset();
        t_plain();
        t_ce();
        t_wr_busy();
        t_rd_busy();
        close_out();
    end
endmodule : testbench

/* hdl/dpbc_host.sv */
// host-side port controller for an asynchronous dual-port RAM with busy
// assumes one port of the RAM is wired to the ram_* pins; busy is open
// drain with pull-up, data pins are resolved by the bench from dout_oe_n
//
// What this block does
// - busy low at the check raises interrupt and snapshots address and rw
// - while busy low, hold capture until an access time after release
// - port selects decoded from address blocks, so busy is released
// - loser may flip an address line and restore it to reread
// - loser may toggle its own select to force a fresh read
`timescale 1ns/10ps
`include "dpbc_regs.svh"

module dpbc_host #(
    parameter int ADDR_LO_W = `DPBC_ADDR_LO_W,
    parameter int BLK_BITS = `DPBC_BLK_BITS,
    parameter int DATA_W = `DPBC_DATA_W,
    parameter int RETRY_CYC = `DPBC_RETRY_CYC,
    parameter int RETRY_MODE = `DPBC_RETRY_SEL
) (
    // clock and control
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // request from the processor side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_LO_W+BLK_BITS-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    // answer to the processor side
    output logic resp_valid,
    output logic [DATA_W-1:0] resp_rdata,
    output logic resp_retried,
    // contention interrupt and snapshot
    output logic snap_irq,
    output dpbc_pkg::dpbc_snap_t snap,
    // memory port pins
    output dpbc_pkg::dpbc_pins_t ram_o,
    input wire logic [DATA_W-1:0] ram_din,
    input wire logic ram_busy_n
);

    localparam int AW = ADDR_LO_W + BLK_BITS;
    localparam int SETTLE = (`DPBC_ACCESS_CYC > `DPBC_MATCH_CYC) ?
        `DPBC_ACCESS_CYC + `DPBC_SYNC_STAGES :
        `DPBC_MATCH_CYC + `DPBC_SYNC_STAGES;
    localparam logic [15:0] SETTLE_C = 16'(SETTLE);
    localparam logic [15:0] RETRY_C = 16'(RETRY_CYC);
    localparam logic [15:0] TOGGLE_C = 16'(`DPBC_TOGGLE_CYC);

    // refuse widths the pin struct cannot carry
    if (ADDR_LO_W != `DPBC_ADDR_LO_W || BLK_BITS != `DPBC_BLK_BITS ||
        DATA_W != `DPBC_DATA_W) begin : g_bad_width
        $error("dpbc_host widths must match the pin struct");
    end
    if (RETRY_CYC < 1 || RETRY_CYC > 65535 ||
        (RETRY_MODE != `DPBC_RETRY_SEL &&
         RETRY_MODE != `DPBC_RETRY_ADDR)) begin : g_bad_retry
        $error("dpbc_host retry settings out of range");
    end

    // whole state of the controller
    typedef struct packed {
        dpbc_pkg::dpbc_state_t st;
        logic [15:0] cnt;
        logic [AW-1:0] addr;
        logic write;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic resp_v;
        logic retried;
        logic irq;
        dpbc_pkg::dpbc_snap_t snap;
    } dpbc_host_state_t;

    dpbc_host_state_t s_q;
    dpbc_host_state_t s_d;
    logic busy_s;
    logic [DATA_W-1:0] din_s;

    // pins come from another domain: two flops before use
    dpbc_sync #(.W(1), .INIT(1'b1)) u_busy_sync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .async_in(ram_busy_n),
        .sync_out(busy_s)
    );
    dpbc_sync #(.W(DATA_W), .INIT('0)) u_data_sync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .async_in(ram_din),
        .sync_out(din_s)
    );

    assign req_ready = ce && (s_q.st == dpbc_pkg::ST_IDLE);

    // next-state logic of the access sequence
    always_comb begin
        s_d = s_q;
        s_d.resp_v = 1'b0;
        s_d.irq = 1'b0;
        case (s_q.st)
            dpbc_pkg::ST_IDLE: begin
                if (req_valid) begin
                    s_d.addr = req_addr;
                    s_d.write = req_write;
                    s_d.wdata = req_wdata;
                    s_d.retried = 1'b0;
                    s_d.cnt = SETTLE_C;
                    s_d.st = dpbc_pkg::ST_SETUP;
                end
            end
            // wait out match delay and access time through the syncs
            dpbc_pkg::ST_SETUP: begin
                if (s_q.cnt == 16'h0000) begin
                    s_d.st = dpbc_pkg::ST_CHECK;
                end else begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end
            end
            dpbc_pkg::ST_CHECK: begin
                if (busy_s) begin
                    // data only trusted with busy high
                    if (!s_q.write) begin
                        s_d.rdata = din_s;
                    end
                    s_d.resp_v = 1'b1;
                    s_d.st = dpbc_pkg::ST_IDLE;
                end else begin
                    // lost: flag it and keep the access for repeat
                    s_d.irq = 1'b1;
                    s_d.snap.addr = s_q.addr;
                    s_d.snap.write = s_q.write;
                    s_d.retried = 1'b1;
                    s_d.cnt = RETRY_C;
                    s_d.st = dpbc_pkg::ST_WAIT;
                end
            end
            // stall while busy low; a blocked write is reissued too
            dpbc_pkg::ST_WAIT: begin
                if (busy_s) begin
                    s_d.cnt = SETTLE_C; // access time after release
                    s_d.st = dpbc_pkg::ST_SETUP;
                end else if (s_q.cnt == 16'h0000) begin
                    s_d.cnt = TOGGLE_C;
                    s_d.st = dpbc_pkg::ST_TOGGLE;
                end else begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end
            end
            // winner camped: toggle our own pins to get a fresh read
            dpbc_pkg::ST_TOGGLE: begin
                if (s_q.cnt == 16'h0000) begin
                    s_d.cnt = SETTLE_C;
                    s_d.st = dpbc_pkg::ST_SETUP;
                end else begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end
            end
            default: begin
                s_d.st = dpbc_pkg::ST_IDLE;
            end
        endcase
    end

    // state register; clock enable freezes everything
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    logic active;
    logic tog;
    assign active = (s_q.st != dpbc_pkg::ST_IDLE);
    assign tog = (s_q.st == dpbc_pkg::ST_TOGGLE);

    // block-decoded one-hot select; released when idle
    for (genvar b = 0; b < (1 << BLK_BITS); b++) begin : g_sel
        assign ram_o.sel_n[b] = !(active &&
            (s_q.addr[AW-1:ADDR_LO_W] == BLK_BITS'(b)) &&
            !(tog && RETRY_MODE == `DPBC_RETRY_SEL));
    end

    // flip address bit 0 during the toggle window
    assign ram_o.addr = s_q.addr[ADDR_LO_W-1:0] ^ ADDR_LO_W'(
        (tog && RETRY_MODE == `DPBC_RETRY_ADDR) ? 1 : 0);
    // no write strobe while an address line is flipped, or the
    // neighbouring location would take the write data
    assign ram_o.rw_n = !(active && s_q.write && !tog);
    assign ram_o.dout = s_q.wdata;
    // drive data only on a write; never while toggling
    assign ram_o.dout_oe_n = !(active && s_q.write && !tog);

    assign resp_valid = s_q.resp_v;
    assign resp_rdata = s_q.rdata;
    assign resp_retried = s_q.retried;
    assign snap_irq = s_q.irq;
    assign snap = s_q.snap;

    AST_SNAP_ON_LOSS: assert property (
        @(posedge clk) disable iff (reset)
        (ce && s_q.st == dpbc_pkg::ST_CHECK && !busy_s)
        |=> snap_irq && snap.addr == $past(s_q.addr)
            && snap.write == $past(s_q.write))
        else $error("contention snapshot not taken");

    AST_NO_ANSWER_UNDER_BUSY: assert property (
        @(posedge clk) disable iff (reset)
        $rose(resp_valid) |-> $past(busy_s)
            && $past(s_q.st) == dpbc_pkg::ST_CHECK)
        else $error("answer given while busy low");

    AST_RELEASE_WAITS_ACCESS: assert property (
        @(posedge clk) disable iff (reset)
        (ce && s_q.st == dpbc_pkg::ST_WAIT && busy_s)
        |=> s_q.st == dpbc_pkg::ST_SETUP && s_q.cnt == SETTLE_C)
        else $error("capture not delayed after busy release");

    AST_IDLE_DESELECTED: assert property (
        @(posedge clk) disable iff (reset)
        s_q.st == dpbc_pkg::ST_IDLE |-> &ram_o.sel_n
            && ram_o.dout_oe_n)
        else $error("select held while idle");

    AST_ONE_BLOCK: assert property (
        @(posedge clk) disable iff (reset)
        $countones(~ram_o.sel_n) <= 1)
        else $error("more than one block selected");

    AST_ADDR_TOGGLE: assert property (
        @(posedge clk) disable iff (reset)
        (tog && RETRY_MODE == `DPBC_RETRY_ADDR)
        |-> ram_o.addr[0] != s_q.addr[0])
        else $error("address line not flipped in toggle");

    AST_NO_WRITE_IN_TOGGLE: assert property (
        @(posedge clk) disable iff (reset)
        tog |-> ram_o.rw_n && ram_o.dout_oe_n)
        else $error("write strobe held during retry toggle");

    AST_SEL_TOGGLE: assert property (
        @(posedge clk) disable iff (reset)
        (ce && s_q.st == dpbc_pkg::ST_WAIT && !busy_s && s_q.cnt == 16'h0000
            && RETRY_MODE == `DPBC_RETRY_SEL)
        |=> &ram_o.sel_n)
        else $error("select not toggled after retry timeout");

endmodule : dpbc_host

/* hdl/dpbc_sync.sv */
// two-flop synchroniser for pin inputs of the memory port
// assumes inputs are asynchronous to clk; clock enable freezes it
`timescale 1ns/10ps

module dpbc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and control
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // pin side and synchronised side
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // first stage is read by the second stage only
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= INIT;
            sync_out <= INIT;
        end else if (ce) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : dpbc_sync

/* inc/dpbc_pkg.sv */
// types shared by the dual-port busy controller
// widths follow dpbc_regs.svh
`include "dpbc_regs.svh"

package dpbc_pkg;

    // access sequence of one port
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_CHECK,
        ST_WAIT,
        ST_TOGGLE
    } dpbc_state_t;

    // everything driven onto the memory port pins
    typedef struct packed {
        logic [`DPBC_ADDR_LO_W-1:0] addr;
        logic [(1<<`DPBC_BLK_BITS)-1:0] sel_n;
        logic rw_n;
        logic [`DPBC_DATA_W-1:0] dout;
        logic dout_oe_n;
    } dpbc_pins_t;

    // contention snapshot for the processor
    typedef struct packed {
        logic [`DPBC_ADDR_LO_W+`DPBC_BLK_BITS-1:0] addr;
        logic write;
    } dpbc_snap_t;

endpackage : dpbc_pkg

/* inc/dpbc_regs.svh */
// timing counts, widths and retry styles for the dual-port busy controller
// assumes a single 20 MHz clock; no software-visible registers exist
`ifndef DPBC_REGS_SVH
`define DPBC_REGS_SVH

// clock period of clk
`define DPBC_CLK_NS 50
// pin widths: low address lines, block-select bits, data lines
`define DPBC_ADDR_LO_W 11
`define DPBC_BLK_BITS 2
`define DPBC_DATA_W 8
// address_access_delay (and busy_release_to_data_delay), in ns
`define DPBC_ACCESS_NS 35
// busy_assert_from_match_delay / busy_assert_from_select_delay, in ns
`define DPBC_MATCH_DELAY_NS 30
// longest internal access pulse of the device, in ns
`define DPBC_PULSE_MAX_NS 11
// synchroniser depth on pin inputs
`define DPBC_SYNC_STAGES 2
// least times round up to whole cycles
`define DPBC_ACCESS_CYC \
    ((`DPBC_ACCESS_NS + `DPBC_CLK_NS - 1) / `DPBC_CLK_NS)
`define DPBC_MATCH_CYC \
    ((`DPBC_MATCH_DELAY_NS + `DPBC_CLK_NS - 1) / `DPBC_CLK_NS)
`define DPBC_TOGGLE_CYC \
    ((`DPBC_PULSE_MAX_NS + `DPBC_CLK_NS - 1) / `DPBC_CLK_NS)
// cycles to wait on a held busy before forcing a fresh access
`define DPBC_RETRY_CYC 16
// retry styles
`define DPBC_RETRY_SEL 0
`define DPBC_RETRY_ADDR 1

`endif
